//--- shared/pin_ctrl_consts.svh
// Offsets, field positions, reset values and timing counts for the pin control block
`ifndef PIN_CTRL_CONSTS_SVH
`define PIN_CTRL_CONSTS_SVH
`define NUM_PINS 60
`define CLK_PINS 4
`define REG_DEF 4'h0
`define REG_FUNC 4'h1
`define REG_MASK 4'h2
`define REG_SEL 4'h3
`define REG_RELAY 4'h4
`define REG_CMP 4'h5
`define REG_CTRL 4'h6
`define REG_BURST 4'h7
`define REG_DELAY 4'h8
`define REG_CMD 4'h9
`define REG_PMU 4'hA
`define REG_STAT 4'hB
`define CTRL_LATCH 0
`define CTRL_CMP_EN 1
`define CTRL_GATE_EN 2
`define CTRL_GATE_LSB 4
`define CTRL_CLKEN_LSB 8
`define CTRL_RESET 16'h0002
`define CMD_START 0
`define CMD_FSTROBE 1
`define CMD_FCLOCK 2
`define CMD_CLRCMP 3
`define CLK_MHZ 100
`define EXTRA_TIME_NS 700
`define EXTRA_CYCLES ((`EXTRA_TIME_NS * `CLK_MHZ + 999) / 1000)
`define MAX_BURST 8'hFF
`endif

//--- shared/pin_ctrl_pkg.sv
// Types shared by the pin control block
package pin_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CLK_HIGH,
        ST_CLK_GAP,
        ST_STROBE_WAIT,
        ST_FCLK
    } seq_state_t;
endpackage

//--- src/pin_ctrl.sv
// Per-pin functional test control: long registers, comparison, auxiliary clock
//
// Functional notes
// - Input pins drive high for pattern 1, low for pattern 0.
// - Output pins use the pattern bit as expected level when comparing.
// - Definition 1 makes input with driver connected; detector always connected.
// - Mask 1 makes a care pin, 0 a don't-care pin.
// - Strobe copies detector results only for care pins.
// - Select 0 picks standard levels and references, 1 the alternate ones.
// - One utility relay per pin; 1 closes it, 0 opens it.
// - Forced strobe captures once even with comparators disabled.
// - Latching off clears comparison register before each test strobe.
// - Latching is off after reset.
// - Latching on accumulates failures across tests.
// - Comparators enabled by default; strobe every functional test.
// - Comparators disabled means no strobe during functional tests.
// - Gated strobe is OR of gate bit AND pattern bit, pins 1-4.
// - Entering gated-strobe mode disables the normal comparator strobe.
// - Burst count sets clocks per test, at most 255.
// - Clock spacing and sync period equal delay plus 0.7 us.
// - Clock-enable bits connect clocks to pins 1-4, removing test circuits.
// - Sync output is clock-enable bit AND pattern bit.
// - Measuring unit on a clock pin opens that pin's clock relay.
// - Forced clock pulses all four syncs for the delay width.
// - Select outputs with reference supplies set drive and threshold levels.
`timescale 1ns/100ps
`include "pin_ctrl_consts.svh"

module pin_ctrl
    import pin_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [63:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [63:0] rdata_out,
    // Pin side
    input wire logic [`NUM_PINS-1:0] level_det_in,
    output logic [`NUM_PINS-1:0] drive_level_out,
    output logic [`NUM_PINS-1:0] driver_connect_out,
    output logic [`NUM_PINS-1:0] ref_alt_sel_out,
    output logic [`NUM_PINS-1:0] utility_relay_out,
    output logic [`CLK_PINS-1:0] clock_connect_out,
    output logic [`CLK_PINS-1:0] sync_out,
    output logic [`CLK_PINS-1:0] clock_pin_relay_drive_out,
    output logic fail_out,
    output logic busy_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [`NUM_PINS-1:0] def_q, func_q, mask_q, sel_q, relay_q, cmp_q;
    logic [15:0] ctrl_q;
    logic [7:0] burst_q;
    logic [15:0] delay_q;
    logic [6:0] pmu_pin_q;
    logic pmu_conn_q;
    logic fail_q;
    seq_state_t state_q;
    logic [7:0] clk_cnt_q;
    logic [16:0] tick_q;
    logic strobe_now;
    logic cap_en;
    logic [`CLK_PINS-1:0] gate_bits, clken_bits;
    logic [`NUM_PINS-1:0] miss;
    logic [16:0] interval;
    logic tick_done;
    logic start_cmd, fstrobe_cmd, fclock_cmd, clr_cmd;

    assign gate_bits = ctrl_q[`CTRL_GATE_LSB +: `CLK_PINS];
    assign clken_bits = ctrl_q[`CTRL_CLKEN_LSB +: `CLK_PINS];
    assign start_cmd = wr_in && addr_in == `REG_CMD && wdata_in[`CMD_START];
    assign fstrobe_cmd = wr_in && addr_in == `REG_CMD && wdata_in[`CMD_FSTROBE];
    assign fclock_cmd = wr_in && addr_in == `REG_CMD && wdata_in[`CMD_FCLOCK];
    assign clr_cmd = wr_in && addr_in == `REG_CMD && wdata_in[`CMD_CLRCMP];
    // Delay plus the fixed 0.7 us overhead
    // interval length
    assign interval = {1'b0, delay_q} + 17'(`EXTRA_CYCLES);
    assign tick_done = tick_q == 17'd1;

    ////////////////////////////////////////////////////////////////////////////
    // Long pin registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            def_q <= '0;
            func_q <= '0;
            mask_q <= '0;
            sel_q <= '0;
            relay_q <= '0;
        end else if (wr_in) begin
            case (addr_in)
                `REG_DEF: def_q <= wdata_in[`NUM_PINS-1:0];
                `REG_FUNC: func_q <= wdata_in[`NUM_PINS-1:0];
                `REG_MASK: mask_q <= wdata_in[`NUM_PINS-1:0];
                `REG_SEL: sel_q <= wdata_in[`NUM_PINS-1:0];
                `REG_RELAY: relay_q <= wdata_in[`NUM_PINS-1:0];
                default: ;
            endcase
        end
    end

    // Control: latch off and comparators on after reset
    // latch default off
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ctrl_q <= `CTRL_RESET;
            burst_q <= '0;
            delay_q <= '0;
            pmu_pin_q <= '0;
            pmu_conn_q <= 1'b0;
        end else if (wr_in) begin
            case (addr_in)
                `REG_CTRL: begin
                    ctrl_q <= wdata_in[15:0];
                    if (wdata_in[`CTRL_GATE_EN])
                        ctrl_q[`CTRL_CMP_EN] <= 1'b0;
                end
                // Eight bits hold 255 at most
                // burst count
                `REG_BURST: burst_q <= wdata_in[7:0];
                `REG_DELAY: delay_q <= wdata_in[15:0];
                `REG_PMU: begin
                    pmu_pin_q <= wdata_in[6:0];
                    pmu_conn_q <= wdata_in[7];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequencer: burst, then strobe one interval later
    // burst then strobe
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            clk_cnt_q <= '0;
            tick_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (fclock_cmd) begin
                        state_q <= ST_FCLK;
                        tick_q <= (delay_q == 16'h0000) ? 17'd1 : {1'b0, delay_q};
                    end else if (start_cmd) begin
                        clk_cnt_q <= burst_q;
                        tick_q <= interval;
                        state_q <= (burst_q == 8'h00) ? ST_STROBE_WAIT : ST_CLK_HIGH;
                    end
                end
                // Clock high for half the period, rounded down
                // clock spacing
                ST_CLK_HIGH: begin
                    tick_q <= tick_q - 17'd1;
                    if (tick_q <= {1'b0, interval[16:1]}) begin
                        state_q <= ST_CLK_GAP;
                    end
                end
                ST_CLK_GAP: begin
                    tick_q <= tick_q - 17'd1;
                    if (tick_done) begin
                        tick_q <= interval;
                        clk_cnt_q <= clk_cnt_q - 8'd1;
                        state_q <= (clk_cnt_q == 8'd1) ? ST_STROBE_WAIT : ST_CLK_HIGH;
                    end
                end
                ST_STROBE_WAIT: begin
                    tick_q <= tick_q - 17'd1;
                    if (tick_done)
                        state_q <= ST_IDLE;
                end
                ST_FCLK: begin
                    tick_q <= tick_q - 17'd1;
                    if (tick_done)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe and compare
    // gated strobe term
    always_comb begin
        strobe_now = 1'b0;
        if (state_q == ST_STROBE_WAIT && tick_done) begin
            if (ctrl_q[`CTRL_GATE_EN])
                strobe_now = |(gate_bits & func_q[`CLK_PINS-1:0]);
            else
                strobe_now = ctrl_q[`CTRL_CMP_EN];
        end
    end
    assign cap_en = strobe_now || fstrobe_cmd;
    // Miss on care pins that are outputs and have no clock connected
    // care compare
    assign miss = (level_det_in ^ func_q) & mask_q & ~def_q
        & ~{{(`NUM_PINS-`CLK_PINS){1'b0}}, clken_bits};

    // Comparison register
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cmp_q <= '0;
        end else if (cap_en) begin
            cmp_q <= ctrl_q[`CTRL_LATCH] ? (cmp_q | miss) : miss;
        end else if (clr_cmd) begin
            cmp_q <= '0;
        end
    end

    // Failure flag; a new failure beats a clear
    always_ff @(posedge ref_clk_in) begin
        if (rst_in)
            fail_q <= 1'b0;
        else if (cap_en && |miss)
            fail_q <= 1'b1;
        else if (clr_cmd)
            fail_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs, all registered
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            drive_level_out <= '0;
            driver_connect_out <= '0;
            ref_alt_sel_out <= '0;
            utility_relay_out <= '0;
            clock_connect_out <= '0;
            sync_out <= '0;
            clock_pin_relay_drive_out <= '0;
            fail_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            drive_level_out <= func_q;
            driver_connect_out <= def_q
                & ~{{(`NUM_PINS-`CLK_PINS){1'b0}}, clken_bits};
            ref_alt_sel_out <= sel_q;
            utility_relay_out <= relay_q;
            clock_connect_out <= clken_bits;
            // sync pulses
            // Forced clock holds every sync high for the whole delay count
            if (state_q == ST_FCLK)
                sync_out <= {`CLK_PINS{1'b1}};
            else if (state_q == ST_CLK_HIGH && tick_q > {1'b0, interval[16:1]} + 17'd1)
                sync_out <= clken_bits & func_q[`CLK_PINS-1:0];
            // A forced clock in the same write wins, so no stray burst edge
            else if (state_q == ST_IDLE && start_cmd && !fclock_cmd && burst_q != 8'h00)
                sync_out <= clken_bits & func_q[`CLK_PINS-1:0];
            else
                sync_out <= '0;
            for (int i = 0; i < `CLK_PINS; i++) begin
                clock_pin_relay_drive_out[i] <= clken_bits[i]
                    && !(pmu_conn_q && pmu_pin_q == 7'(i + 1));
            end
            fail_out <= fail_q;
            busy_out <= (state_q != ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read, one cycle later
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                `REG_DEF: rdata_out <= {4'h0, def_q};
                `REG_FUNC: rdata_out <= {4'h0, func_q};
                `REG_MASK: rdata_out <= {4'h0, mask_q};
                `REG_SEL: rdata_out <= {4'h0, sel_q};
                `REG_RELAY: rdata_out <= {4'h0, relay_q};
                `REG_CMP: rdata_out <= {4'h0, cmp_q};
                `REG_CTRL: rdata_out <= {48'h0000_0000_0000, ctrl_q};
                `REG_BURST: rdata_out <= {56'h0000_0000_0000_00, burst_q};
                `REG_DELAY: rdata_out <= {48'h0000_0000_0000, delay_q};
                `REG_PMU: rdata_out <= {56'h0000_0000_0000_00, pmu_conn_q, pmu_pin_q};
                `REG_STAT: rdata_out <= {61'h0, fail_q, state_q != ST_IDLE, 1'b0};
                default: rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_forced_strobe_caps: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        fstrobe_cmd && !ctrl_q[`CTRL_LATCH] |=> cmp_q == $past(miss))
        else $error("forced strobe did not capture");
    a_latch_accumulates: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cap_en && ctrl_q[`CTRL_LATCH] |=> (cmp_q & $past(cmp_q)) == $past(cmp_q))
        else $error("latched failures lost");
    a_no_strobe_disabled: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !fstrobe_cmd && !clr_cmd && !ctrl_q[`CTRL_CMP_EN] && !ctrl_q[`CTRL_GATE_EN]
        |=> $stable(cmp_q))
        else $error("strobe while comparators disabled");
    a_gate_disables_cmp: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_in && addr_in == `REG_CTRL && wdata_in[`CTRL_GATE_EN] |=> !ctrl_q[`CTRL_CMP_EN])
        else $error("gated strobe left comparators on");
    a_drive_follows: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ##1 drive_level_out == $past(func_q))
        else $error("drive level wrong");
    a_relay_follows: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_in && addr_in == `REG_RELAY |=> ##1 utility_relay_out == $past(wdata_in[59:0], 2))
        else $error("relay not updated");
    a_sync_gated: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q != ST_FCLK |=> (sync_out & ~($past(clken_bits) & $past(func_q[3:0]))) == 4'h0)
        else $error("sync outside enable");
    a_pmu_opens_relay: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        pmu_conn_q && pmu_pin_q inside {[7'd1:7'd4]}
        |=> !clock_pin_relay_drive_out[$past(pmu_pin_q[1:0]) - 2'd1])
        else $error("clock relay not opened");
    a_fclk_sync_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == ST_FCLK |=> sync_out == 4'hF)
        else $error("forced clock sync low");
    a_latch_off_replace: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cap_en && !ctrl_q[`CTRL_LATCH] |=> cmp_q == $past(miss))
        else $error("comparison not replaced");
    a_care_only: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cap_en && !ctrl_q[`CTRL_LATCH] |=> (cmp_q & ~$past(mask_q)) == '0)
        else $error("don't-care pin captured");
    c_forced_clock: cover property (@(posedge ref_clk_in) state_q == ST_FCLK);
    c_burst_strobe: cover property (@(posedge ref_clk_in) strobe_now);
    c_gated_strobe: cover property (@(posedge ref_clk_in) strobe_now && ctrl_q[`CTRL_GATE_EN]);
    c_latched_fail: cover property (@(posedge ref_clk_in) cap_en && ctrl_q[`CTRL_LATCH] && |miss);
endmodule

//--- test/dut_board_model.sv
// Behavioural part under test sitting on the load board
`timescale 1ns/100ps
`include "pin_ctrl_consts.svh"

module dut_board_model (
    // Tester pin side
    input wire logic [`NUM_PINS-1:0] drive_level_in,
    input wire logic [`NUM_PINS-1:0] driver_connect_in,
    // Part outputs chosen by the bench
    input wire logic [`NUM_PINS-1:0] resp_in,
    // Level seen by the detectors
    output logic [`NUM_PINS-1:0] pin_level_out
);
    ////////////////////////////////////////////////////////////////////////////
    // driven pins echo tester
    // Delay keeps the detector inputs clear of the sampling edge
    assign #2 pin_level_out = (drive_level_in & driver_connect_in)
        | (resp_in & ~driver_connect_in);
endmodule

//--- test/functional_test_pin_control_test.sv
// Register-level bench for the pin control block
`timescale 1ns/100ps
`include "pin_ctrl_consts.svh"

module functional_test_pin_control_test;
    localparam int D = 5;
    localparam int IV = D + 70;
    localparam logic [59:0] DEF = 60'h000_0000_0000_0031;
    localparam logic [59:0] FUNC = 60'h5A5_A5A5_A5A5_A5A5;
    localparam logic [59:0] MASK = 60'hFFF_FFFF_FFFF_FF3F;
    localparam logic [59:0] F1 = 60'h000_0000_0001_00D6;
    localparam logic [59:0] F2 = 60'h800_0000_0000_0008;
    logic ref_clk_in, rst_in, wr_in, rd_in, fail, busy, busy_prev;
    logic [3:0] addr_in, clk_conn, sync, relay_drv, sync_prev;
    logic [63:0] wdata_in, rdata_out, rv;
    logic [59:0] level_det, drive_lvl, drv_conn, alt_sel, util_relay, resp;
    int error_cnt, comparisons, cyc, rises0, rises2, odd_sync, last_rise, prev_rise;
    int fall_cyc, fw, r0, r2, od, f0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #600000;
        error_cnt++;
        results();
    end

    pin_ctrl dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .level_det_in(level_det), .drive_level_out(drive_lvl),
        .driver_connect_out(drv_conn), .ref_alt_sel_out(alt_sel),
        .utility_relay_out(util_relay), .clock_connect_out(clk_conn), .sync_out(sync),
        .clock_pin_relay_drive_out(relay_drv), .fail_out(fail), .busy_out(busy));
    dut_board_model board (.drive_level_in(drive_lvl), .driver_connect_in(drv_conn),
        .resp_in(resp), .pin_level_out(level_det));

    // Sync pulse and busy monitor, counted in clock cycles
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        sync_prev <= sync;
        busy_prev <= busy;
        if (sync[0] && !sync_prev[0]) begin
            rises0 <= rises0 + 1;
            prev_rise <= last_rise;
            last_rise <= cyc;
        end
        if (sync[2] && !sync_prev[2]) rises2 <= rises2 + 1;
        if (sync[1] || sync[3]) odd_sync <= odd_sync + 1;
        if (sync === 4'hF) fw <= fw + 1;
        if (!busy && busy_prev) fall_cyc <= cyc;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus and comparison tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [63:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rcheck(input logic [3:0] a, input logic [63:0] exp);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 check(rdata_out, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask
    // Start a test, then wait a bounded time for the sequencer to go idle
    task automatic run_test();
        int n;
        wr(`REG_CMD, 64'h0000_0000_0000_0001);
        settle();
        for (n = 0; n < 40000 && busy !== 1'b0; n++) begin
            @(posedge ref_clk_in);
            #1;
        end
        check(64'(n < 40000), 64'h0000_0000_0000_0001);
        settle();
    endtask
    function automatic logic [59:0] miss(input logic [59:0] flt, input logic [3:0] ce);
        return flt & MASK & ~DEF & ~{56'h0, ce};
    endfunction
    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 64'h0;
        resp = FUNC;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1 check({drive_lvl, sync}, 64'h0);
        rcheck(`REG_CTRL, 64'h0000_0000_0000_0002);
        wr(`REG_DEF, 64'(DEF));
        wr(`REG_FUNC, 64'(FUNC));
        wr(`REG_MASK, 64'(MASK));
        wr(`REG_DELAY, 64'(D));
        wr(`REG_RELAY, 64'hFFFF_FFFF_FFFF_FFFF);
        settle();
        check(64'(util_relay), 64'h0FFF_FFFF_FFFF_FFFF);
        rcheck(`REG_RELAY, 64'h0FFF_FFFF_FFFF_FFFF);
        wr(`REG_RELAY, 64'(F1));
        settle();
        check(64'(util_relay), 64'(F1));
        check(64'(drive_lvl), 64'(FUNC));
        check(64'(drv_conn), 64'(DEF));
        // Latch off: each test replaces the comparison result; latch on then accumulates it
        resp = FUNC ^ F1;
        run_test();
        rcheck(`REG_CMP, 64'(miss(F1, 4'h0)));
        check(64'(fail), 64'h1);
        rcheck(`REG_STAT, 64'h0000_0000_0000_0004);
        resp = FUNC ^ F2;
        run_test();
        rcheck(`REG_CMP, 64'(miss(F2, 4'h0)));
        wr(`REG_CTRL, 64'h0000_0000_0000_0003);
        resp = FUNC ^ F1;
        run_test();
        rcheck(`REG_CMP, 64'(miss(F1, 4'h0) | miss(F2, 4'h0)));
        // Comparators off, then a forced strobe
        wr(`REG_CMD, 64'h0000_0000_0000_0008);
        wr(`REG_CTRL, 64'h0000_0000_0000_0000);
        run_test();
        rcheck(`REG_CMP, 64'h0);
        wr(`REG_CMD, 64'h0000_0000_0000_0002);
        rcheck(`REG_CMP, 64'(miss(F1, 4'h0)));
        // Gated strobe on a pin with pattern 0, then on one with pattern 1
        wr(`REG_CMD, 64'h0000_0000_0000_0008);
        wr(`REG_CTRL, 64'h0000_0000_0000_0026);
        rcheck(`REG_CTRL, 64'h0000_0000_0000_0024);
        run_test();
        rcheck(`REG_CMP, 64'h0);
        wr(`REG_CTRL, 64'h0000_0000_0000_0044);
        run_test();
        rcheck(`REG_CMP, 64'(miss(F1, 4'h0)));
        // Burst of three clocks, pins 1 to 3 connected, pulses on pins 1 and 3 only
        wr(`REG_CTRL, 64'h0000_0000_0000_0702);
        wr(`REG_BURST, 64'h0000_0000_0000_0003);
        settle();
        check(64'(clk_conn), 64'h7);
        check(64'(drv_conn), 64'(DEF & ~60'h7));
        r0 = rises0;
        r2 = rises2;
        od = odd_sync;
        run_test();
        check(64'(rises0 - r0), 64'd3);
        check(64'(rises2 - r2), 64'd3);
        check(64'(odd_sync - od), 64'd0);
        check(64'(last_rise - prev_rise), 64'(IV));
        check(64'(fall_cyc - last_rise >= IV && fall_cyc - last_rise <= 2 * IV + 4), 64'h1);
        rcheck(`REG_CMP, 64'(miss(F1, 4'h7)));
        // Longest burst
        wr(`REG_BURST, 64'h0000_0000_0000_00FF);
        r0 = rises0;
        run_test();
        check(64'(rises0 - r0), 64'd255);
        // Forced clock: width set by the delay
        f0 = fw;
        wr(`REG_CMD, 64'h0000_0000_0000_0004);
        repeat (10) settle();
        check(64'(fw - f0), 64'(D));
        // Measuring unit parked on pin 2 opens its clock relay
        wr(`REG_CTRL, 64'h0000_0000_0000_0F02);
        settle();
        check(64'(relay_drv), 64'hF);
        wr(`REG_PMU, 64'h0000_0000_0000_0082);
        settle();
        check(64'(relay_drv), 64'hD);
        wr(`REG_PMU, 64'h0000_0000_0000_0002);
        settle();
        check(64'(relay_drv), 64'hF);
        // Unmapped places
        rcheck(4'hC, 64'h0);
        wr(4'hD, 64'hFFFF_FFFF_FFFF_FFFF);
        rcheck(`REG_CTRL, 64'h0000_0000_0000_0F02);
        // select switched last
        // No functional test follows, so the relay settle time is not waited out
        wr(`REG_SEL, 64'(MASK));
        settle();
        check(64'(alt_sel), 64'(MASK));
        // Mid-run reset brings back the default control word
        rst_in <= 1'b1;
        settle();
        rst_in <= 1'b0;
        check(64'(util_relay), 64'h0);
        rcheck(`REG_CTRL, 64'h0000_0000_0000_0002);
        results();
    end
endmodule
